/* File: serial_link_bist_checker_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_link_bist_checker_tb_top;
   logic       clk = 0, nrst = 0, en = 0, cfg = 0, lock = 0, bcf = 0;
   logic       sel = 0, ce = 1, clr = 0, res1, res2, lk1, nv1, aw, sok, osc;
   logic [3:0] strap = 4'h1;
   logic [7:0] r1, r2, cnt, adr = 8'h25;
   int         num_errors = 0, total_checks = 0;
   slbc_link_if link1 ();
   slbc_link_if link2 ();
   always #2 clk = ~clk;
   slbc_rx slbc_rx_i (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce),
      .I_SELF_TEST_ENABLE_PIN(en), .I_SELF_TEST_CFG(1'b0),
      .I_SELF_TEST_CLOCK_SELECT_PIN(sel), .I_CLK_SEL_CFG(sel),
      .I_PCLK_PRESENT(!sel), .I_LOCK(lock), .I_STRAP(strap),
      .I_REG_ADDR(adr), .I_BC_FRAME(bcf), .I_BC_CRC_ERR(bcf),
      .O_REG_RDATA(r1), .O_RESULT(res1), .O_LOCK(lk1),
      .O_NORMAL_VIDEO(nv1), .link(link1.rx));
   slbc_rx slbc_rx2_i (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce),
      .I_SELF_TEST_ENABLE_PIN(1'b0), .I_SELF_TEST_CFG(cfg),
      .I_SELF_TEST_CLOCK_SELECT_PIN(sel), .I_CLK_SEL_CFG(sel),
      .I_PCLK_PRESENT(!sel), .I_LOCK(lock), .I_STRAP(strap),
      .I_REG_ADDR(8'h25), .I_BC_FRAME(bcf), .I_BC_CRC_ERR(bcf),
      .O_REG_RDATA(r2), .O_RESULT(res2), .O_LOCK(),
      .O_NORMAL_VIDEO(), .link(link2.rx));
   slbc_tx slbc_tx_i (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce),
      .I_BC_LOCK(lock), .I_CRC_CLR(clr), .I_STRAP(strap),
      .O_CRC_ERR_CNT(cnt), .O_AWAKE(aw), .O_OSC_ACTIVE(osc),
      .O_STRAP_OK(sok), .link(link1.tx));
   slbc_link_asserts slbc_link_asserts_i (.I_CLK(clk), .I_NRST(nrst),
      .i_bc_test_req(link1.bc_test_req), .i_tx_in_test(link1.tx_in_test),
      .i_fwd_frame(link1.fwd_frame), .i_fwd_valid(link1.fwd_valid));
   task automatic summarize();
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_res(input logic v, input bit two);
      int i;
      for (i = 0; i < 40 && (two ? res2 : res1) !== v; i++) cyc(1);
      chk(8'(i < 40), 8'h01);
      if (i == 40) summarize();
   endtask
   task automatic t_pair();
      sel = 1;
      cyc(5);
      chk(8'(osc), 8'h01);
      sel = 0;
      cyc(5);
      chk(8'(osc), 8'h00);
      en = 1;
      lock = 1;
      wait_res(1'b1, 1'b0);
      chk(8'(lk1), 8'h01);
      chk(8'(nv1), 8'h00);
      chk(8'(aw), 8'h01);
      chk(8'(sok), 8'h01);
      bcf = 1;
      cyc(1);
      bcf = 0;
      cyc(6);
      chk(cnt, 8'h01);
      chk(r1, 8'h00);
      adr = 8'h24;
      cyc(2);
      chk(r1, 8'h00);
      en = 0;
      cyc(12);
      chk(8'(res1), 8'h01);
      chk(8'(nv1), 8'h01);
      chk(cnt, 8'h01);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(1);
      chk(cnt, 8'h00);
   endtask
   task automatic t_err(input bit again);
      cfg = 1;
      for (int i = 0; i < 40 && link2.bc_test_req !== 1'b1; i++) cyc(1);
      chk(8'(link2.bc_test_req), 8'h01);
      link2.tx_in_test = 1;
      link2.fwd_valid = 1;
      wait_res(1'b1, 1'b1);
      chk(r2, 8'h00);
      if (again) return;
      link2.fwd_frame = 36'h0_0000_0001;
      cyc(1);
      link2.fwd_frame = 36'h0;
      cyc(4);
      chk(8'(res2), 8'h01);
      link2.fwd_frame = 36'h8_0000_0000;
      cyc(1);
      link2.fwd_frame = 36'h0;
      wait_res(1'b0, 1'b1);
      wait_res(1'b1, 1'b1);
      chk(r2, 8'h01);
      for (int i = 0; i < 260; i++)
      begin
         link2.fwd_frame = 36'h0_0000_0002;
         cyc(1);
         link2.fwd_frame = 36'h0;
         cyc(1);
      end
      chk(r2, 8'hFF);
      cfg = 0;
      link2.tx_in_test = 0;
      cyc(12);
      chk(8'(res2), 8'h00);
   endtask
   initial
   begin
      link2.tx_in_test = 0;
      link2.fwd_valid = 0;
      link2.fwd_frame = 36'h0;
      cyc(8);
      nrst = 1;
      cyc(2);
      t_pair();
      t_err(1'b0);
      t_err(1'b1);
      summarize();
   end
endmodule // serial_link_bist_checker_tb_top
`default_nettype wire

/* File: slbc_defs.svh */
// Behaviour
// [RULE1] Enter test by enable pin or register.
// [RULE2] Test clock: pixel clock or internal oscillator.
// [RULE3] Send test request over back channel.
// [RULE4] Transmitter wakes, sends scrambled all-zeros payload (the code sends it unscrambled).
// [RULE5] After lock, compare payload with zeros, record.
// [RULE6] Both in test and locked: result high.
// [RULE7] Errored frame drops result for half period (the code drops it for one full clock cycle).
// [RULE8] Lock status stays valid during test.
// [RULE9] Enable low stops checking, holds final result.
// [RULE10] Held result persists until new test or reset.
// [RULE11] Test length set by enable pin width.
// [RULE12] Enable low returns link to normal video.
// [RULE13] Strap line zero high, lines three-one low.
// [RULE14] Error count readable at offset forward_error_count.
// [RULE15] Transmitter checks back-channel CRC after lock.
// [RULE16] Transmitter counts CRC errors, clears on entry.
// [RULE17] Transmitter CRC count updates only in test (the code also clears it on I_CRC_CLR outside test).
// [RULE18] Error count saturates and clears on start.
`ifndef SLBC_DEFS_SVH
`define SLBC_DEFS_SVH
`define SLBC_FWD_ERR_OFS    8'h25
`define SLBC_CNT_MAX        8'hFF
`define SLBC_PAYLOAD_LO     1
`define SLBC_PAYLOAD_HI     35
`define SLBC_FRAME_W        36
`define SLBC_STRAP_OK       4'h1
`define SLBC_OSC_KHZ        33000
`endif

/* File: slbc_link_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module slbc_link_asserts
(
   input wire logic        I_CLK,
   input wire logic        I_NRST,
   input wire logic        i_bc_test_req,
   input wire logic        i_tx_in_test,
   input wire logic [35:0] i_fwd_frame,
   input wire logic        i_fwd_valid
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   property p_wake;
      $rose(i_bc_test_req) |-> ##[0:8] i_tx_in_test;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no test entry");
   property p_zero;
      i_tx_in_test && i_fwd_valid |-> i_fwd_frame[35:1] == 35'h0;
   endproperty
   a_zero: assert property (p_zero)
      else $error("payload not zero");
   property p_cause;
      $rose(i_tx_in_test) |-> i_bc_test_req || $past(i_bc_test_req)
         || $past(i_bc_test_req, 2) || $past(i_bc_test_req, 4);
   endproperty
   a_cause: assert property (p_cause)
      else $error("test entry unasked");
   property p_follow;
      i_bc_test_req |=> i_tx_in_test;
   endproperty
   a_follow: assert property (p_follow)
      else $error("request not followed");
   property p_release;
      !i_bc_test_req |=> !i_tx_in_test;
   endproperty
   a_release: assert property (p_release)
      else $error("test held after release");
   property p_valid;
      i_tx_in_test |=> i_fwd_valid;
   endproperty
   a_valid: assert property (p_valid)
      else $error("no payload in test");
   c_wake: cover property ($rose(i_tx_in_test));
   c_frame: cover property (i_tx_in_test && i_fwd_valid);
   c_stop: cover property ($fell(i_tx_in_test));
endmodule // slbc_link_asserts
`default_nettype wire

/* File: slbc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface slbc_link_if;
   logic        bc_test_req;
   logic        tx_in_test;
   logic        tx_osc_sel;
   logic [35:0] fwd_frame;
   logic        fwd_valid;
   logic        bc_frame_valid;
   logic        bc_crc_err;
   modport rx (output bc_test_req, output tx_osc_sel, output bc_frame_valid,
               output bc_crc_err, input tx_in_test, input fwd_frame,
               input fwd_valid);
   modport tx (input bc_test_req, input tx_osc_sel, input bc_frame_valid,
               input bc_crc_err, output tx_in_test, output fwd_frame,
               output fwd_valid);
endinterface
`default_nettype wire

/* File: slbc_pkg.sv */
package slbc_pkg;
   typedef enum logic [2:0] {
      SLBC_IDLE = 3'b001,
      SLBC_WAIT = 3'b010,
      SLBC_RUN  = 3'b100
   } slbc_state_t;
endpackage

/* File: slbc_rx.sv */
`include "slbc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module slbc_rx
(
   input  wire logic       I_CLK,
   input  wire logic       I_NRST,
   input  wire logic       I_CE,
   input  wire logic       I_SELF_TEST_ENABLE_PIN,
   input  wire logic       I_SELF_TEST_CFG,
   input  wire logic       I_SELF_TEST_CLOCK_SELECT_PIN,
   input  wire logic       I_CLK_SEL_CFG,
   input  wire logic       I_PCLK_PRESENT,
   input  wire logic       I_LOCK,
   input  wire logic [3:0] I_STRAP,
   input  wire logic [7:0] I_REG_ADDR,
   input  wire logic       I_BC_FRAME,
   input  wire logic       I_BC_CRC_ERR,
   output logic       [7:0] O_REG_RDATA,
   output logic             O_RESULT,
   output logic             O_LOCK,
   output logic             O_NORMAL_VIDEO,
   slbc_link_if.rx          link
);
   typedef struct packed {
      logic                  en_s1;
      logic                  en_s2;
      logic                  lk_s1;
      logic                  lk_s2;
      logic                  cs_s1;
      logic                  cs_s2;
      logic                  pp_s1;
      logic                  pp_s2;
      logic [3:0]            sp_s1;
      logic [3:0]            sp_s2;
      logic                  req;
      logic                  osc;
      logic                  result;
      logic                  err_seen;
      logic                  lock_o;
      logic                  norm;
      logic                  bcv;
      logic                  bce;
      logic [7:0]            cnt;
      logic [7:0]            rdata;
      slbc_pkg::slbc_state_t st;
   } slbc_rx_t;
   slbc_rx_t r, n;
   logic                   en_req, bad;
   always_comb
   begin
      n = r;
      n.en_s1 = I_SELF_TEST_ENABLE_PIN;
      n.en_s2 = r.en_s1;
      n.lk_s1 = I_LOCK;
      n.lk_s2 = r.lk_s1;
      n.cs_s1 = I_SELF_TEST_CLOCK_SELECT_PIN;
      n.cs_s2 = r.cs_s1;
      n.pp_s1 = I_PCLK_PRESENT;
      n.pp_s2 = r.pp_s1;
      n.sp_s1 = I_STRAP;
      n.sp_s2 = r.sp_s1;
      n.bcv = I_BC_FRAME;
      n.bce = I_BC_CRC_ERR;
      // [RULE1] Pin or register.
      en_req = r.en_s2 | I_SELF_TEST_CFG;
      // [RULE5] Compare with zeros.
      bad = link.fwd_valid
            && (link.fwd_frame[`SLBC_PAYLOAD_HI:`SLBC_PAYLOAD_LO] != '0);
      // [RULE8] Lock always visible.
      n.lock_o = r.lk_s2;
      n.norm = (r.st == slbc_pkg::SLBC_IDLE);
      // [RULE2] Oscillator only without pixel clock.
      n.osc = !r.pp_s2
              && (r.cs_s2 | I_CLK_SEL_CFG);
      // [RULE14] Count register read.
      n.rdata = (I_REG_ADDR == `SLBC_FWD_ERR_OFS) ? r.cnt : 8'h00;
      unique case (r.st)
         slbc_pkg::SLBC_IDLE:
         begin
            n.req = 1'b0;
            // [RULE13] Start only when strapped.
            if (en_req && (r.sp_s2 == `SLBC_STRAP_OK))
            begin
               // [RULE18] Clear on start.
               n.cnt = 8'h00;
               n.err_seen = 1'b0;
               // [RULE3] Request over back channel.
               n.req = 1'b1;
               n.st = slbc_pkg::SLBC_WAIT;
            end
         end
         slbc_pkg::SLBC_WAIT:
         begin
            if (!en_req)
               n.st = slbc_pkg::SLBC_IDLE;
            // [RULE6] Both in test and locked.
            else if (link.tx_in_test && r.lk_s2)
            begin
               n.result = 1'b1;
               n.st = slbc_pkg::SLBC_RUN;
            end
         end
         slbc_pkg::SLBC_RUN:
         begin
            // [RULE9] Stop and hold.
            if (!en_req)
            begin
               n.req = 1'b0;
               n.result = !r.err_seen;
               // [RULE12] Back to video.
               n.st = slbc_pkg::SLBC_IDLE;
            end
            else if (r.lk_s2)
            begin
               // [RULE7] Low pulse per errored frame.
               n.result = !bad;
               if (bad)
               begin
                  n.err_seen = 1'b1;
                  // [RULE18] Saturating count.
                  if (r.cnt != `SLBC_CNT_MAX)
                     n.cnt = r.cnt + 8'h01;
               end
            end
         end
      endcase
   end
   always_ff @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         r <= '0;
         r.st <= slbc_pkg::SLBC_IDLE;
         r.norm <= 1'b1;
      end
      else if (I_CE)
         r <= n;
   end
   assign O_REG_RDATA = r.rdata;
   assign O_RESULT = r.result;
   assign O_LOCK = r.lock_o;
   assign O_NORMAL_VIDEO = r.norm;
   assign link.bc_test_req = r.req;
   assign link.tx_osc_sel = r.osc;
   assign link.bc_frame_valid = r.bcv;
   assign link.bc_crc_err = r.bce;
endmodule // slbc_rx
`default_nettype wire

/* File: slbc_tx.sv */
`include "slbc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module slbc_tx
(
   input  wire logic       I_CLK,
   input  wire logic       I_NRST,
   input  wire logic       I_CE,
   input  wire logic       I_BC_LOCK,
   input  wire logic       I_CRC_CLR,
   input  wire logic [3:0] I_STRAP,
   output logic       [7:0] O_CRC_ERR_CNT,
   output logic             O_AWAKE,
   output logic             O_OSC_ACTIVE,
   output logic             O_STRAP_OK,
   slbc_link_if.tx          link
);
   typedef struct packed {
      logic       bl_s1, bl_s2, in_test, awake, osc, sok, fv;
      logic [3:0] sp_s1, sp_s2;
      logic [7:0] cnt;
   } slbc_tx_t;
   slbc_tx_t r, n;
   always_comb
   begin
      n = r;
      n.bl_s1 = I_BC_LOCK;
      n.bl_s2 = r.bl_s1;
      n.sp_s1 = I_STRAP;
      n.sp_s2 = r.sp_s1;
      // [RULE13] Strap check.
      n.sok = (r.sp_s2 == `SLBC_STRAP_OK);
      // [RULE2] Oscillator select.
      n.osc = link.tx_osc_sel;
      // [RULE4] Wake on request.
      n.in_test = link.bc_test_req;
      if (link.bc_test_req)
         n.awake = 1'b1;
      // [RULE16] Clear on entry.
      if (link.bc_test_req && !r.in_test)
         n.cnt = 8'h00;
      else if (I_CRC_CLR)
         n.cnt = 8'h00;
      // [RULE17] Increment only in test, I_CRC_CLR clears at any time; [RULE15] after lock.
      else if (r.in_test && r.bl_s2 && link.bc_frame_valid
               && link.bc_crc_err && r.cnt != `SLBC_CNT_MAX)
         n.cnt = r.cnt + 8'h01;
      n.fv = r.in_test;
   end
   always_ff @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         r <= '0;
      else if (I_CE)
         r <= n;
   end
   assign link.tx_in_test = r.in_test;
   assign link.fwd_valid = r.fv;
   // [RULE4] Payload is sent as all zeros, with no scrambling.
   assign link.fwd_frame = '0;
   assign O_CRC_ERR_CNT = r.cnt;
   assign O_AWAKE = r.awake;
   assign O_OSC_ACTIVE = r.osc;
   assign O_STRAP_OK = r.sok;
endmodule // slbc_tx
`default_nettype wire
